/* File: logic/mcu_pkg.sv */
// Package: register map, field positions and channel codes for config 2
// How it works
// - Bit 4 set turns measurement averaging off for faster conversions.
// - Bit 5 set disconnects the attenuator from the 2.5 V input.
// - Bit 6 set converts only the selected channel, repeatedly.
// - In single-channel mode, test bit 2 starts conversions from external clock.
// - Single-channel selection comes from fan1_min_high_byte bits 7 to 5.
// - Codes: 000 2.5 V, 010 supply, 101 remote1, 110 local, 111 remote2.
// - Bit 7 set enters shutdown; every PWM output goes inactive.
// - During shutdown the current duty registers read 0x00.
// - Once the lock bit is one, writes to this register are ignored.
// - Power-on value of the register is all zeros.
package mcu_pkg;
  localparam logic [7:0] MCU_ADDR_CFG2    = 8'h73;
  localparam logic [7:0] MCU_ADDR_FAN1MIN = 8'h55;
  localparam logic [7:0] MCU_ADDR_TEST2   = 8'h7F;
  localparam logic [7:0] MCU_CFG2_RESET   = 8'h00;
  localparam logic [7:0] MCU_DUTY_OFF     = 8'h00;
  localparam int MCU_BIT_AVERAGING = 4;
  localparam int MCU_BIT_BYPASS    = 5;
  localparam int MCU_BIT_SINGLE    = 6;
  localparam int MCU_BIT_PWRDN     = 7;
  localparam int MCU_BIT_EXTCLK    = 2;
  localparam int MCU_NUM_CH = 5;
  localparam logic [2:0] MCU_CODE_2V5 = 3'h0;
  localparam logic [2:0] MCU_CODE_VCC = 3'h2;
  localparam logic [2:0] MCU_CODE_R1  = 3'h5;
  localparam logic [2:0] MCU_CODE_LT  = 3'h6;
  localparam logic [2:0] MCU_CODE_R2  = 3'h7;
endpackage

/* File: logic/mcu_sync2.sv */
// Module: two-flop synchroniser for an external pin
`timescale 1ns/1ps
module mcu_sync2
(
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_ff;
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_ff <= 1'b0;
      o_q     <= 1'b0;
    end
    else
    begin
      meta_ff <= i_d;
      o_q     <= meta_ff;
    end
  end
endmodule

/* File: logic/mcu_config2.sv */
// Module: configuration register 2 upper bits and their control outputs
`timescale 1ns/1ps
module mcu_config2
#(
  parameter int NUM_PWM = 3
)
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_wr_en,
  input  wire logic [7:0]         i_wr_addr,
  input  wire logic [7:0]         i_wr_data,
  input  wire logic [7:0]         i_rd_addr,
  input  wire logic               i_lock,
  input  wire logic [7:0]         i_fan1_min_high_byte,
  input  wire logic [7:0]         i_test2,
  input  wire logic               i_ext_single_channel_convert_clk,
  input  wire logic [NUM_PWM-1:0] i_pwm_raw,
  input  wire logic [NUM_PWM-1:0] i_pwm_invert,
  input  wire logic [7:0]         i_duty_raw,
  output logic      [7:0]         o_rd_data,
  output logic      [7:0]         o_duty_rd,
  output logic      [NUM_PWM-1:0] o_pwm,
  output logic                    o_averaging_disable,
  output logic                    o_attenuator_bypass,
  output logic                    o_single_channel_convert,
  output logic                    o_power_down_control,
  output logic                    o_ext_single_channel_convert_start,
  output logic                    o_single_channel_convert_start_ext_mode,
  output logic      [4:0]         o_channel_onehot
);
  import mcu_pkg::*;

  logic [7:0] cfg_ff;
  logic       ext_sync;
  logic       ext_prev_ff;

  // One-hot channel decode; unlisted codes select nothing
  function automatic logic [4:0] ch_decode(input logic [2:0] code);
    logic [4:0] r;
    r = 5'h00;
    case (code)
      MCU_CODE_2V5: r = 5'h01;
      MCU_CODE_VCC: r = 5'h02;
      MCU_CODE_R1:  r = 5'h04;
      MCU_CODE_LT:  r = 5'h08;
      MCU_CODE_R2:  r = 5'h10;
      default:      r = 5'h00;
    endcase
    return r;
  endfunction

  mcu_sync2 u_sync
  (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_d       (i_ext_single_channel_convert_clk),
    .o_q       (ext_sync)
  );

  // Register; lock freezes it; low nibble belongs to the fan logic
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      cfg_ff <= MCU_CFG2_RESET;
    else if (i_wr_en && i_wr_addr == MCU_ADDR_CFG2 && !i_lock)
      cfg_ff <= {i_wr_data[7:4], 4'h0};
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_rd_data <= 8'h00;
    else if (i_rd_addr == MCU_ADDR_CFG2)
      o_rd_data <= cfg_ff;
    else
      o_rd_data <= 8'h00;
  end

  // Mode outputs follow the register one cycle later, so clearing resumes
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_averaging_disable      <= 1'b0;
      o_attenuator_bypass      <= 1'b0;
      o_single_channel_convert <= 1'b0;
      o_power_down_control     <= 1'b0;
    end
    else
    begin
      o_averaging_disable      <= cfg_ff[MCU_BIT_AVERAGING];
      o_attenuator_bypass      <= cfg_ff[MCU_BIT_BYPASS];
      o_single_channel_convert <= cfg_ff[MCU_BIT_SINGLE];
      o_power_down_control     <= cfg_ff[MCU_BIT_PWRDN];
    end
  end

  // Channel and external start only matter in single-channel mode
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_channel_onehot      <= 5'h00;
      o_single_channel_convert_start_ext_mode <= 1'b0;
      o_ext_single_channel_convert_start      <= 1'b0;
      ext_prev_ff           <= 1'b0;
    end
    else
    begin
      ext_prev_ff <= ext_sync;
      o_channel_onehot <= cfg_ff[MCU_BIT_SINGLE] ?
        ch_decode(i_fan1_min_high_byte[7:5]) : 5'h00;
      o_single_channel_convert_start_ext_mode <= cfg_ff[MCU_BIT_SINGLE] &&
        i_test2[MCU_BIT_EXTCLK];
      o_ext_single_channel_convert_start <= cfg_ff[MCU_BIT_SINGLE] &&
        i_test2[MCU_BIT_EXTCLK] && ext_sync && !ext_prev_ff;
    end
  end

  // Shutdown overrides PWM pins and duty readback
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_pwm     <= '0;
      o_duty_rd <= 8'h00;
    end
    else
    begin
      o_pwm     <= cfg_ff[MCU_BIT_PWRDN] ? i_pwm_invert : i_pwm_raw;
      o_duty_rd <= cfg_ff[MCU_BIT_PWRDN] ? MCU_DUTY_OFF : i_duty_raw;
    end
  end

  property p_lock_hold;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    i_lock |=> $stable(cfg_ff);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("Locked register changed");

  property p_pwrdn_pwm;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    cfg_ff[MCU_BIT_PWRDN] |=> (o_pwm == $past(i_pwm_invert));
  endproperty
  a_pwrdn_pwm: assert property (p_pwrdn_pwm)
    else $error("PWM not inactive in shutdown");

  property p_pwrdn_duty;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    cfg_ff[MCU_BIT_PWRDN] |=> (o_duty_rd == 8'h00);
  endproperty
  a_pwrdn_duty: assert property (p_pwrdn_duty)
    else $error("Duty readback not zero in shutdown");

  property p_pwrdn_flag;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    cfg_ff[MCU_BIT_PWRDN] |=> o_power_down_control;
  endproperty
  a_pwrdn_flag: assert property (p_pwrdn_flag)
    else $error("Shutdown flag not raised");

  property p_resume;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    !cfg_ff[MCU_BIT_PWRDN] |=> (o_pwm == $past(i_pwm_raw));
  endproperty
  a_resume: assert property (p_resume)
    else $error("PWM not passed through");

  property p_write;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (i_wr_en && i_wr_addr == MCU_ADDR_CFG2 && !i_lock) |=>
      (cfg_ff == {$past(i_wr_data[7:4]), 4'h0}) ##1
      (o_averaging_disable == $past(i_wr_data[MCU_BIT_AVERAGING], 2));
  endproperty
  a_write: assert property (p_write)
    else $error("Write did not take effect");

  property p_average_on;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    $fell(cfg_ff[MCU_BIT_AVERAGING]) |=> !o_averaging_disable;
  endproperty
  a_average_on: assert property (p_average_on)
    else $error("Averaging not restored");

  property p_bypass;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    $rose(cfg_ff[MCU_BIT_BYPASS]) |=> o_attenuator_bypass;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Attenuator bypass late");

  property p_single;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    $rose(cfg_ff[MCU_BIT_SINGLE]) |=> o_single_channel_convert;
  endproperty
  a_single: assert property (p_single)
    else $error("Single-channel mode late");

  property p_multi;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    !cfg_ff[MCU_BIT_SINGLE] |=> (o_channel_onehot == 5'h00)
      && !o_ext_single_channel_convert_start && !o_single_channel_convert;
  endproperty
  a_multi: assert property (p_multi)
    else $error("Single-channel outputs active in multi mode");

  property p_chan;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (cfg_ff[MCU_BIT_SINGLE] && i_fan1_min_high_byte[7:5] == 3'h5)
      |=> (o_channel_onehot == 5'h04);
  endproperty
  a_chan: assert property (p_chan)
    else $error("Remote 1 not selected");

  property p_ext;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_ext_single_channel_convert_start |-> o_single_channel_convert_start_ext_mode || $past(o_single_channel_convert_start_ext_mode);
  endproperty
  a_ext: assert property (p_ext)
    else $error("External start outside external mode");

  // A held-high pin must not retrigger conversions
  property p_ext_pulse;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_ext_single_channel_convert_start |=> !o_ext_single_channel_convert_start;
  endproperty
  a_ext_pulse: assert property (p_ext_pulse)
    else $error("External start longer than one cycle");
endmodule

/* File: tb/mcu_host_model.sv */
// Host model driving the register write and read ports of config 2
`timescale 1ns/1ps
module mcu_host_model
(
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_rd_data,
  output logic            o_wr_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_data
);
  initial
  begin
    o_wr_en = 1'b0;
    o_addr  = 8'h00;
    o_data  = 8'h00;
  end
  // One strobe per call; data scrambled after release
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_wr_en = 1'b1;
    o_addr  = a;
    o_data  = d;
    @(negedge i_ref_clk);
    o_wr_en = 1'b0;
    o_data  = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_ref_clk);
    o_addr = a;
    @(negedge i_ref_clk);
    d = i_rd_data;
  endtask
endmodule

/* File: tb/test_mcu_config2.sv */
// Testbench for configuration register 2 upper bits
`timescale 1ns/1ps
module test_mcu_config2;
  import mcu_pkg::*;
  logic       i_ref_clk = 1'b0;
  logic       i_resetn = 1'b0;
  logic       lock = 1'b0;
  logic [7:0] fmin = 8'h00;
  logic [7:0] t2 = 8'h00;
  logic       ext = 1'b0;
  logic [2:0] praw = 3'h5;
  logic [2:0] pinv = 3'h6;
  logic [7:0] duty = 8'h5A;
  logic       wr_en, no_average, bypass, single, pwr_down, xs, xm;
  logic [7:0] addr, wdat, rdat, duty_rd, v;
  logic [2:0] pwm;
  logic [4:0] oh;
  logic [7:0] modes;
  logic [2:0] codes [6] = '{MCU_CODE_2V5, MCU_CODE_VCC, MCU_CODE_R1,
                            MCU_CODE_LT, MCU_CODE_R2, 3'h1};
  int         mismatches = 0;
  int         n_checks = 0;
  int         hits;
  always #2 i_ref_clk = ~i_ref_clk;
  assign modes = {4'h0, pwr_down, single, bypass, no_average};
  mcu_host_model host
  (
    .i_ref_clk(i_ref_clk), .i_rd_data(rdat), .o_wr_en(wr_en),
    .o_addr(addr), .o_data(wdat)
  );
  mcu_config2 #(.NUM_PWM(3)) DUT
  (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_wr_en(wr_en),
    .i_wr_addr(addr), .i_wr_data(wdat), .i_rd_addr(addr), .i_lock(lock),
    .i_fan1_min_high_byte(fmin), .i_test2(t2), .i_ext_single_channel_convert_clk(ext),
    .i_pwm_raw(praw), .i_pwm_invert(pinv), .i_duty_raw(duty),
    .o_rd_data(rdat), .o_duty_rd(duty_rd), .o_pwm(pwm),
    .o_averaging_disable(no_average), .o_attenuator_bypass(bypass),
    .o_single_channel_convert(single), .o_power_down_control(pwr_down),
    .o_ext_single_channel_convert_start(xs), .o_single_channel_convert_start_ext_mode(xm),
    .o_channel_onehot(oh)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    w(20);
    i_resetn = 1'b1;
    host.rd(MCU_ADDR_CFG2, v);
    chk(v, MCU_CFG2_RESET);
    chk(modes, 8'h00);
    host.wr(MCU_ADDR_CFG2, 8'hFF);
    w(2);
    chk(modes, 8'h0F);
    chk({5'h0, pwm}, {5'h0, pinv});
    chk(duty_rd, MCU_DUTY_OFF);
    host.rd(MCU_ADDR_CFG2, v);
    chk(v, 8'hF0);
    for (int i = 0; i < 6; i++)
    begin
      fmin = {codes[i], 5'h1F};
      w(3);
      chk({3'h0, oh}, (i < 5) ? 8'(1 << i) : 8'h00);
    end
    // In single-channel mode, a held-high external pin gives one start pulse
    t2 = 8'h04;
    w(3);
    chk({7'h0, xm}, 8'h01);
    ext = 1'b1;
    hits = 0;
    for (int i = 0; i < 8; i++)
    begin
      w(1);
      hits += int'(xs);
    end
    chk(8'(hits), 8'h01);
    host.wr(MCU_ADDR_CFG2, 8'h00);
    w(2);
    chk({5'h0, pwm}, {5'h0, praw});
    chk(duty_rd, duty);
    chk({2'h0, xm, oh}, 8'h00);
    lock = 1'b1;
    host.wr(MCU_ADDR_CFG2, 8'hF0);
    w(2);
    host.rd(MCU_ADDR_CFG2, v);
    chk(v, 8'h00);
    chk({7'h0, pwr_down}, 8'h00);
    host.rd(MCU_ADDR_FAN1MIN, v);
    chk(v, 8'h00);
    // Unlocked again; distinct patterns catch swapped bit wiring
    lock = 1'b0;
    host.wr(MCU_ADDR_CFG2, 8'h5A);
    w(2);
    chk(modes, 8'h05);
    host.rd(MCU_ADDR_CFG2, v);
    chk(v, 8'h50);
    host.wr(MCU_ADDR_CFG2, 8'hA0);
    w(2);
    chk(modes, 8'h0A);
    chk({5'h0, pwm}, {5'h0, pinv});
    // Reset in mid-run brings back the power-on state
    i_resetn = 1'b0;
    w(2);
    i_resetn = 1'b1;
    host.rd(MCU_ADDR_CFG2, v);
    chk(v, MCU_CFG2_RESET);
    chk(modes, 8'h00);
    chk({5'h0, pwm}, {5'h0, praw});
    finish_test();
  end
endmodule
